// File: rtl/ppm_pkg.sv
/*
  Package for the parallel port mode control block: register offsets, mode
  register field layout, codes, timing constants and carrier structs.
  Assumes a single 50 MHz peripheral clock and the plain strobe register port.
*/
// Notes on behaviour
// [RULE1] busy flag bit 15, set during transfers
// [RULE2] irq mode: none, per cycle, buffer 3
// [RULE3] address step: hold, increment, decrement
// [RULE4] step code 11 walks slave buffers, legacy
// [RULE5] chip-select address bits 14/15 never step
// [RULE6] width bit picks one 16 or 8-bit transfer
// [RULE7] codes 11/10 select master modes 1/2
// [RULE8] codes 01/00 select enhanced/legacy slave
// [RULE9] setup wait is field plus one cycles
// [RULE10] zero strobe wait forces fixed setup/hold
// [RULE11] read-input captures only when dual buffer set
// [RULE12] dual buffer clear: reads use shared register
// [RULE13] upper sixteen bits read zero, ignore writes
// [RULE14] strobe and hold widths follow their fields
// [RULE15] all implemented fields reset to zero
package ppm_pkg;
  // ==========================================================
  // register map (offsets chosen for this block)
  localparam logic [3:0] PPM_ADDR_MODE = 4'h0;
  localparam logic [3:0] PPM_ADDR_CTRL = 4'h1;
  localparam logic [3:0] PPM_ADDR_ADDR = 4'h2;
  localparam logic [3:0] PPM_ADDR_DATA = 4'h3;
  localparam logic [3:0] PPM_ADDR_RDIN = 4'h4;
  localparam logic [3:0] PPM_ADDR_STAT = 4'h5;
  localparam logic [3:0] PPM_ADDR_MASK = 4'h6;
  // ==========================================================
  // mode register fields
  localparam int PPM_BUSY_BIT = 15;
  localparam int PPM_DUAL_BUFFER_ENABLE_BIT = 17;
  localparam logic [15:0] PPM_MODE_WMASK = 16'h7FFF;
  localparam logic [1:0] PPM_IRQ_NONE = 2'h0;
  localparam logic [1:0] PPM_IRQ_CYCLE = 2'h1;
  localparam logic [1:0] PPM_IRQ_BUF3 = 2'h2;
  localparam logic [1:0] PPM_STEP_HOLD = 2'h0;
  localparam logic [1:0] PPM_STEP_INC = 2'h1;
  localparam logic [1:0] PPM_STEP_DEC = 2'h2;
  localparam logic [1:0] PPM_STEP_BUF = 2'h3;
  localparam logic [1:0] PPM_MODE_LEGACY = 2'h0;
  localparam logic [1:0] PPM_MODE_ENH = 2'h1;
  localparam logic [1:0] PPM_MODE_M2 = 2'h2;
  localparam logic [1:0] PPM_MODE_M1 = 2'h3;
  localparam logic [1:0] PPM_BUF3 = 2'h3;
  localparam logic [3:0] PPM_STROBE_WAIT_CYCLES_ZERO = 4'h0;
  localparam logic [3:0] PPM_ONE4 = 4'h1;
  localparam logic [15:0] PPM_ONE16 = 16'h0001;
  // ==========================================================
  // timing: one peripheral clock period at 50 MHz
  localparam int PPM_CLK_MHZ = 50;
  localparam int PPM_TPB_NS = 20;
  localparam int PPM_TPB_CYC = (PPM_TPB_NS * PPM_CLK_MHZ + 999) / 1000;
  // ==========================================================
  // carriers
  typedef struct packed {
    logic [1:0] irq_mode_sel;
    logic [1:0] addr_step_mode;
    logic wide_transfer_sel;
    logic [1:0] port_mode;
    logic [1:0] setup_wait_cycles;
    logic [3:0] strobe_wait_cycles;
    logic [1:0] hold_wait_cycles;
  } ppm_mode_type;
  typedef struct packed {
    logic [3:0] setup;
    logic [3:0] strobe;
    logic [3:0] hold;
  } ppm_timing_type;
  typedef enum logic [3:0] {
    PPM_IDLE = 4'b0001,
    PPM_SETUP = 4'b0010,
    PPM_STROBE = 4'b0100,
    PPM_HOLD = 4'b1000
  } ppm_phase_type;
endpackage

// File: rtl/ppm_wait_calc.sv
/*
  Converts the mode register wait fields into phase lengths in clock cycles.
  Assumes the fields come straight from the mode register.
*/
`timescale 1ns/1ps
`default_nettype none
module ppm_wait_calc
  import ppm_pkg::*;
(
  input wire ppm_mode_type mode,
  input wire logic is_read,
  output ppm_timing_type timing
);
  // ==========================================================
  // phase lengths
  always_comb
  begin
    if (mode.strobe_wait_cycles == PPM_STROBE_WAIT_CYCLES_ZERO) // RULE10
    begin
      timing.setup = PPM_ONE4;
      timing.strobe = PPM_ONE4;
      timing.hold = is_read ? 4'h0 : PPM_ONE4;
    end
    else
    begin
      timing.setup = {2'h0, mode.setup_wait_cycles} + PPM_ONE4; // RULE9
      timing.strobe = mode.strobe_wait_cycles; // RULE14
      timing.hold = {2'h0, mode.hold_wait_cycles}; // RULE14
    end
  end
endmodule
`default_nettype wire

// File: rtl/ppm_addr_step.sv
/*
  Next-address logic for the port address after each read/write cycle.
  Assumes chip-select use of bits 14 and 15 is given as two enables.
*/
`timescale 1ns/1ps
`default_nettype none
module ppm_addr_step
  import ppm_pkg::*;
(
  input wire logic [15:0] addr,
  input wire logic [1:0] step_mode,
  input wire logic [1:0] cs_en,
  output logic [15:0] addr_next
);
  logic [15:0] stepped;
  // ==========================================================
  // step and hold chip-select bits
  always_comb
  begin
    case (step_mode) // RULE3
      PPM_STEP_INC: stepped = addr + PPM_ONE16;
      PPM_STEP_DEC: stepped = addr - PPM_ONE16;
      default: stepped = addr;
    endcase
    addr_next = stepped;
    // chip-select bits keep their level; a carry still passes a held bit 14 into bit 15 when bit 15 is not held
    if (cs_en[0])
      addr_next[14] = addr[14]; // RULE5
    if (cs_en[1])
      addr_next[15] = addr[15]; // RULE5
  end
endmodule
`default_nettype wire

// File: rtl/ppm_top.sv
/*
  Parallel port mode control: mode register, dual-buffer read input,
  master strobe sequencer, slave buffer access and interrupt.
  Assumes a plain synchronous register port and synchronous pin inputs.
*/
// The register offsets and the plain strobed port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module ppm_top
  import ppm_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic irq,
  input wire logic [15:0] port_data_in,
  output logic [15:0] port_data_out,
  output logic [15:0] port_data_oe,
  output logic [15:0] port_addr_lines,
  output logic [1:0] port_chip_selects,
  output logic port_read_strobe,
  output logic port_write_strobe,
  output logic port_enable_strobe,
  input wire logic host_cs,
  input wire logic host_rd,
  input wire logic host_wr,
  input wire logic [1:0] host_addr
);
  typedef struct packed {
    ppm_mode_type mode;
    logic [1:0] cs_en;
    logic dual_buffer_enable;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic [15:0] shared_data_in_reg;
    logic [15:0] read_input_value;
    logic busy;
    ppm_phase_type phase;
    logic [3:0] cnt;
    logic is_read;
    logic [1:0] sts;
    logic [1:0] msk;
    logic [1:0] slv_ptr;
    logic host_act;
    logic [31:0] rdata;
    logic irq;
    logic [15:0] pd_out;
    logic [15:0] pd_oe;
    logic rd_s;
    logic wr_s;
    logic en_s;
    logic [1:0] cs_o;
  } ppm_state_type;

  ppm_state_type s_q, s_d;
  ppm_timing_type tim;
  logic [15:0] addr_next;
  logic is_master;
  logic host_edge;
  logic [1:0] host_idx;

  ppm_wait_calc u_wait (
    .mode(s_q.mode),
    .is_read(s_q.is_read),
    .timing(tim)
  );

  ppm_addr_step u_step (
    .addr(s_q.addr),
    .step_mode(s_q.mode.addr_step_mode),
    .cs_en(s_q.cs_en),
    .addr_next(addr_next)
  );

  function automatic logic sel(input logic [3:0] a, input logic [3:0] b);
    sel = (a == b);
  endfunction

  assign is_master = s_q.mode.port_mode[1]; // RULE7 RULE8
  // host access starts on the first cycle of chip select with a strobe
  assign host_edge = host_cs && (host_rd || host_wr) && !s_q.host_act;
  // legacy slave walks buffers only in step code 11, else buffer 0
  assign host_idx = (s_q.mode.port_mode == PPM_MODE_ENH) ? host_addr : // RULE8
                    ((s_q.mode.addr_step_mode == PPM_STEP_BUF) ? s_q.slv_ptr : 2'h0); // RULE4

  // ==========================================================
  // next state
  always_comb
  begin
    s_d = s_q;
    s_d.rdata = 32'h0;
    s_d.host_act = host_cs && (host_rd || host_wr);
    // register writes
    if (reg_wr)
    begin
      if (sel(reg_addr, PPM_ADDR_MODE))
        s_d.mode = ppm_mode_type'(reg_wdata[14:0] & PPM_MODE_WMASK[14:0]); // RULE13
      else if (sel(reg_addr, PPM_ADDR_CTRL))
      begin
        s_d.dual_buffer_enable = reg_wdata[PPM_DUAL_BUFFER_ENABLE_BIT];
        s_d.cs_en = reg_wdata[1:0];
      end
      else if (sel(reg_addr, PPM_ADDR_ADDR))
        s_d.addr = reg_wdata[15:0];
      else if (sel(reg_addr, PPM_ADDR_RDIN))
        s_d.read_input_value = reg_wdata[15:0]; // RULE13
      else if (sel(reg_addr, PPM_ADDR_MASK))
        s_d.msk = reg_wdata[1:0];
      else if (sel(reg_addr, PPM_ADDR_DATA))
      begin
        s_d.wdata = reg_wdata[15:0];
        s_d.shared_data_in_reg = reg_wdata[15:0];
      end
    end
    // register reads
    if (reg_rd)
    begin
      if (sel(reg_addr, PPM_ADDR_MODE))
        s_d.rdata = {16'h0, s_q.busy, 15'(s_q.mode)}; // RULE1 RULE13
      else if (sel(reg_addr, PPM_ADDR_CTRL))
        s_d.rdata = {14'h0, s_q.dual_buffer_enable, 15'h0, s_q.cs_en};
      else if (sel(reg_addr, PPM_ADDR_ADDR))
        s_d.rdata = {16'h0, s_q.addr};
      else if (sel(reg_addr, PPM_ADDR_DATA))
        s_d.rdata = {16'h0, s_q.shared_data_in_reg}; // RULE12
      else if (sel(reg_addr, PPM_ADDR_RDIN))
        s_d.rdata = {16'h0, s_q.read_input_value}; // RULE13
      else if (sel(reg_addr, PPM_ADDR_STAT))
        s_d.rdata = {30'h0, s_q.sts};
      else if (sel(reg_addr, PPM_ADDR_MASK))
        s_d.rdata = {30'h0, s_q.msk};
      else
        s_d.rdata = 32'h0;
    end
    // status clear by writing one; a same-cycle event set below wins
    if (reg_wr && sel(reg_addr, PPM_ADDR_STAT))
      s_d.sts = s_q.sts & ~reg_wdata[1:0];
    // master sequencer: one data access starts exactly one transfer
    case (s_q.phase)
      PPM_IDLE:
      begin
        if (is_master && (reg_wr || reg_rd) && sel(reg_addr, PPM_ADDR_DATA)) // RULE6
        begin
          s_d.is_read = reg_rd;
          s_d.busy = 1'b1; // RULE1
          s_d.cnt = 4'h1;
          s_d.phase = PPM_SETUP;
          s_d.cs_o = ~s_q.cs_en | 2'h0;
          s_d.pd_oe = reg_wr ? (s_q.mode.wide_transfer_sel ? 16'hFFFF : 16'h00FF) : 16'h0000;
          s_d.pd_out = reg_wdata[15:0];
        end
      end
      PPM_SETUP:
      begin
        s_d.cnt = s_q.cnt + PPM_ONE4;
        if (s_q.cnt >= tim.setup) // RULE9
        begin
          s_d.cnt = 4'h1;
          s_d.phase = PPM_STROBE;
          if (s_q.mode.port_mode == PPM_MODE_M1) // RULE7
          begin
            s_d.en_s = 1'b1;
            s_d.rd_s = s_q.is_read;
          end
          else
          begin
            s_d.rd_s = s_q.is_read;
            s_d.wr_s = !s_q.is_read;
          end
        end
      end
      PPM_STROBE:
      begin
        s_d.cnt = s_q.cnt + PPM_ONE4;
        if (s_q.cnt >= tim.strobe) // RULE14
        begin
          s_d.en_s = 1'b0;
          s_d.wr_s = 1'b0;
          s_d.rd_s = (s_q.mode.port_mode == PPM_MODE_M1) ? s_d.rd_s : 1'b0;
          s_d.cnt = 4'h1;
          s_d.phase = PPM_HOLD;
          if (s_q.is_read)
          begin
            if (s_q.dual_buffer_enable)
              s_d.read_input_value = s_q.mode.wide_transfer_sel ? port_data_in : {8'h0, port_data_in[7:0]}; // RULE11
            else
              s_d.shared_data_in_reg = s_q.mode.wide_transfer_sel ? port_data_in : {8'h0, port_data_in[7:0]}; // RULE12
          end
        end
      end
      PPM_HOLD:
      begin
        s_d.cnt = s_q.cnt + PPM_ONE4;
        if (s_q.cnt > tim.hold) // RULE14
        begin
          s_d.phase = PPM_IDLE;
          s_d.busy = 1'b0;
          s_d.rd_s = 1'b0;
          s_d.pd_oe = 16'h0000;
          s_d.cs_o = 2'h0;
          s_d.addr = addr_next; // RULE3 RULE5
          if (s_q.mode.irq_mode_sel == PPM_IRQ_CYCLE)
            s_d.sts[0] = 1'b1; // RULE2
        end
      end
      default:
        s_d.phase = PPM_IDLE;
    endcase
    // slave accesses from the external host
    if (!is_master && host_edge)
    begin
      if (host_wr)
        s_d.shared_data_in_reg = {8'h0, port_data_in[7:0]};
      if (s_q.mode.irq_mode_sel == PPM_IRQ_CYCLE)
        s_d.sts[0] = 1'b1; // RULE2
      if (s_q.mode.irq_mode_sel == PPM_IRQ_BUF3 && host_idx == PPM_BUF3)
        s_d.sts[1] = 1'b1; // RULE2
      if (s_q.mode.port_mode == PPM_MODE_LEGACY && s_q.mode.addr_step_mode == PPM_STEP_BUF)
        s_d.slv_ptr = s_q.slv_ptr + 2'h1; // RULE4
    end
    if (!is_master)
    begin
      s_d.pd_out = {8'h0, s_q.wdata[7:0]};
      s_d.pd_oe = (host_cs && host_rd) ? 16'h00FF : 16'h0000;
    end
    s_d.irq = |(s_d.sts & s_d.msk);
  end

  // ==========================================================
  // state register
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      s_q <= '{phase: PPM_IDLE, default: '0}; // RULE15
    else
      s_q <= s_d;
  end

  assign reg_rdata = s_q.rdata;
  assign irq = s_q.irq;
  assign port_data_out = s_q.pd_out;
  assign port_data_oe = s_q.pd_oe;
  assign port_addr_lines = s_q.addr;
  assign port_chip_selects = s_q.cs_o;
  assign port_read_strobe = s_q.rd_s;
  assign port_write_strobe = s_q.wr_s;
  assign port_enable_strobe = s_q.en_s;

  // ==========================================================
  // checks
  property p_busy_read;
    @(posedge mclk) disable iff (rst)
    reg_rd && sel(reg_addr, PPM_ADDR_MODE) |=> reg_rdata[PPM_BUSY_BIT] == $past(s_q.busy);
  endproperty
  a_busy_read: assert property (p_busy_read) else $error("busy bit misread"); // RULE1

  property p_upper_zero;
    @(posedge mclk) disable iff (rst)
    reg_rd && (sel(reg_addr, PPM_ADDR_MODE) || sel(reg_addr, PPM_ADDR_RDIN)) |=> reg_rdata[31:16] == 16'h0;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper bits not zero"); // RULE13

  property p_no_irq_mode0;
    @(posedge mclk) disable iff (rst)
    s_q.mode.irq_mode_sel == PPM_IRQ_NONE && s_q.sts == 2'h0 && !reg_wr |=> s_q.sts == 2'h0;
  endproperty
  a_no_irq_mode0: assert property (p_no_irq_mode0) else $error("irq raised in mode 0"); // RULE2

  property p_start_busy;
    @(posedge mclk) disable iff (rst)
    s_q.phase == PPM_IDLE && is_master && reg_wr && sel(reg_addr, PPM_ADDR_DATA) |=> s_q.busy ##1 s_q.busy;
  endproperty
  a_start_busy: assert property (p_start_busy) else $error("transfer did not go busy"); // RULE6

  property p_hold_addr;
    @(posedge mclk) disable iff (rst)
    s_q.mode.addr_step_mode == PPM_STEP_HOLD && s_q.phase == PPM_HOLD && !reg_wr |=> $stable(s_q.addr);
  endproperty
  a_hold_addr: assert property (p_hold_addr) else $error("address moved in hold mode"); // RULE3

  property p_cs_bits;
    @(posedge mclk) disable iff (rst)
    s_q.cs_en[1] && !(reg_wr && sel(reg_addr, PPM_ADDR_ADDR)) |=> s_q.addr[15] == $past(s_q.addr[15]);
  endproperty
  a_cs_bits: assert property (p_cs_bits) else $error("chip-select bit stepped"); // RULE5

  property p_dual_off;
    @(posedge mclk) disable iff (rst)
    !s_q.dual_buffer_enable && !(reg_wr && sel(reg_addr, PPM_ADDR_RDIN)) |=> $stable(s_q.read_input_value);
  endproperty
  a_dual_off: assert property (p_dual_off) else $error("read input captured while off"); // RULE11

  property p_setup_len;
    @(posedge mclk) disable iff (rst)
    $rose(s_q.phase == PPM_SETUP) && s_q.mode.strobe_wait_cycles == PPM_STROBE_WAIT_CYCLES_ZERO |=> s_q.phase == PPM_STROBE;
  endproperty
  a_setup_len: assert property (p_setup_len) else $error("setup not one cycle"); // RULE10

  property p_slave_no_strobe;
    @(posedge mclk) disable iff (rst)
    s_q.phase == PPM_IDLE |-> !port_write_strobe && !port_enable_strobe;
  endproperty
  a_slave_no_strobe: assert property (p_slave_no_strobe) else $error("strobe while idle"); // RULE7
endmodule
`default_nettype wire

// File: test/ppm_periph.sv
/*
  Model of the external peripheral on the parallel port: one storage word.
  Assumes registered strobes from the port sequencer and one shared clock.
*/
`timescale 1ns/1ps
`default_nettype none
module ppm_periph
(
  input wire logic mclk,
  input wire logic [15:0] port_data_out,
  input wire logic [15:0] port_data_oe,
  input wire logic port_read_strobe,
  input wire logic port_write_strobe,
  input wire logic port_enable_strobe,
  output logic [15:0] port_data_in
);
  // ==========================================================
  // storage and bus drive
  logic [15:0] mem_q = 16'h0000;
  logic [15:0] idle_q = 16'h0000;
  always_ff @(posedge mclk)
  begin
    // released bus toggles so a stale capture cannot pass
    idle_q <= ~idle_q;
    if ((port_write_strobe || port_enable_strobe) && (port_data_oe != 16'h0000))
    begin
      mem_q <= port_data_out & port_data_oe;
    end
  end
  assign port_data_in = port_read_strobe ? mem_q : idle_q;
endmodule
`default_nettype wire

// File: test/ppm_top_bench.sv
/*
  Self-checking bench for the parallel port mode control block.
  Assumes the register port of the package and the peripheral model beside it.
*/
`timescale 1ns/1ps
`default_nettype none
module ppm_top_bench
  import ppm_pkg::*;
;
  logic mclk, rst, reg_wr, reg_rd, irq, host_cs, host_rd, host_wr;
  logic port_read_strobe, port_write_strobe, port_enable_strobe;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rv;
  logic [15:0] port_data_in, port_data_out, port_data_oe, port_addr_lines;
  logic [1:0] port_chip_selects, host_addr;
  int errors = 0;
  int total_checks = 0;
  int cycles = 0;
  ppm_top uut (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .port_data_in(port_data_in),
    .port_data_out(port_data_out), .port_data_oe(port_data_oe), .port_addr_lines(port_addr_lines),
    .port_chip_selects(port_chip_selects), .port_read_strobe(port_read_strobe),
    .port_write_strobe(port_write_strobe), .port_enable_strobe(port_enable_strobe),
    .host_cs(host_cs), .host_rd(host_rd), .host_wr(host_wr), .host_addr(host_addr));
  ppm_periph periph (.mclk(mclk), .port_data_out(port_data_out), .port_data_oe(port_data_oe),
    .port_read_strobe(port_read_strobe), .port_write_strobe(port_write_strobe),
    .port_enable_strobe(port_enable_strobe), .port_data_in(port_data_in));
  // ==========================================================
  // bus and check helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  task automatic wait_idle();
    logic [31:0] m;
    for (int i = 0; i < 40; i++)
    begin
      rd(PPM_ADDR_MODE, m);
      if (m[PPM_BUSY_BIT] === 1'b0)
      begin
        break;
      end
      // a transfer that never ends must not slip through
      if (i == 39)
      begin
        chk({31'h00000000, m[PPM_BUSY_BIT]}, 32'h0);
      end
    end
  endtask
  function automatic logic [31:0] mw(logic [1:0] iq, logic [1:0] st, logic w, logic [1:0] md,
    logic [1:0] wb, logic [3:0] wm);
    return {17'h00000, iq, st, w, md, wb, wm, 2'h1};
  endfunction
  // ==========================================================
  // scenarios
  task automatic t_reset();
    chk({28'h0000000, port_read_strobe, port_write_strobe, port_enable_strobe, irq}, 32'h0);
    rd(PPM_ADDR_MODE, rv);
    chk(rv, 32'h0);
    rd(PPM_ADDR_RDIN, rv);
    chk(rv, 32'h0);
    wr(4'h7, 32'hFFFFFFFF);
    rd(4'h7, rv);
    chk(rv, 32'h0);
    wr(PPM_ADDR_MODE, 32'hFFFFFFFF);
    rd(PPM_ADDR_MODE, rv);
    chk(rv, 32'h00007FFF);
    wr(PPM_ADDR_MODE, 32'h0);
    $display("reset test done");
  endtask
  task automatic t_timing(input logic rdop, input logic [1:0] md, input logic w, input logic [1:0] wb,
    input logic [3:0] wm, input int pre_exp);
    int pre;
    int stb;
    logic s;
    logic [15:0] dout;
    logic [15:0] oe;
    pre = 0;
    stb = 0;
    dout = 16'h0000;
    oe = 16'h0000;
    wr(PPM_ADDR_MODE, mw(PPM_IRQ_NONE, PPM_STEP_HOLD, w, md, wb, wm));
    if (rdop)
    begin
      rd(PPM_ADDR_DATA, rv);
    end
    else
    begin
      wr(PPM_ADDR_DATA, 32'h0000A55A);
    end
    for (int i = 0; i < 60; i++)
    begin
      s = rdop ? port_read_strobe : ((md == PPM_MODE_M1) ? port_enable_strobe : port_write_strobe);
      if (s === 1'b1)
      begin
        stb++;
        dout = port_data_out & port_data_oe;
        oe = port_data_oe;
      end
      else if (stb == 0)
      begin
        pre++;
      end
      else
      begin
        break;
      end
      @(posedge mclk);
      #1;
    end
    chk(pre, pre_exp);
    chk(stb, (wm == PPM_STROBE_WAIT_CYCLES_ZERO) ? 32'h1 : {28'h0000000, wm});
    chk({16'h0000, oe}, rdop ? 32'h0 : (w ? 32'h0000FFFF : 32'h000000FF));
    chk({16'h0000, dout}, rdop ? 32'h0 : (w ? 32'h0000A55A : 32'h0000005A));
    wait_idle();
    $display("timing test done");
  endtask
  task automatic t_dual();
    wr(PPM_ADDR_CTRL, 32'h00020000);
    wr(PPM_ADDR_MODE, mw(PPM_IRQ_NONE, PPM_STEP_HOLD, 1'b1, PPM_MODE_M2, 2'h0, 4'h2));
    wr(PPM_ADDR_DATA, 32'h0000A55A);
    wait_idle();
    rd(PPM_ADDR_DATA, rv);
    wait_idle();
    rd(PPM_ADDR_RDIN, rv);
    chk(rv, 32'h0000A55A);
    wr(PPM_ADDR_CTRL, 32'h0);
    wr(PPM_ADDR_MODE, mw(PPM_IRQ_NONE, PPM_STEP_HOLD, 1'b0, PPM_MODE_M2, 2'h0, 4'h2));
    wr(PPM_ADDR_DATA, 32'h000012C3);
    wait_idle();
    rd(PPM_ADDR_DATA, rv);
    wait_idle();
    rd(PPM_ADDR_RDIN, rv);
    chk(rv, 32'h0000A55A);
    rd(PPM_ADDR_DATA, rv);
    chk(rv, 32'h000000C3);
    wait_idle();
    wr(PPM_ADDR_RDIN, 32'hFFFFFFFF);
    rd(PPM_ADDR_RDIN, rv);
    chk(rv, 32'h0000FFFF);
    $display("dual buffer test done");
  endtask
  task automatic t_step(input logic [15:0] a, input logic [1:0] st, input logic [1:0] cs, input logic [15:0] e);
    wr(PPM_ADDR_CTRL, {30'h00000000, cs});
    wr(PPM_ADDR_ADDR, {16'h0000, a});
    wr(PPM_ADDR_MODE, mw(PPM_IRQ_NONE, st, 1'b1, PPM_MODE_M2, 2'h0, 4'h8));
    wr(PPM_ADDR_DATA, 32'h00000001);
    rd(PPM_ADDR_MODE, rv);
    chk({31'h00000000, rv[PPM_BUSY_BIT]}, 32'h1);
    chk({30'h00000000, port_chip_selects}, {30'h00000000, ~cs});
    wait_idle();
    rd(PPM_ADDR_ADDR, rv);
    chk(rv, {16'h0000, e});
    chk({16'h0000, port_addr_lines}, {16'h0000, e});
    $display("address step test done");
  endtask
  task automatic t_irq(input logic [1:0] iq, input logic [31:0] mk, input logic [31:0] es);
    wr(PPM_ADDR_MASK, mk);
    wr(PPM_ADDR_MODE, mw(iq, PPM_STEP_HOLD, 1'b1, PPM_MODE_M2, 2'h0, 4'h1));
    wr(PPM_ADDR_DATA, 32'h00000001);
    wait_idle();
    rd(PPM_ADDR_STAT, rv);
    chk(rv, es);
    chk({31'h00000000, irq}, {31'h00000000, |(es & mk)});
    wr(PPM_ADDR_STAT, es);
    rd(PPM_ADDR_STAT, rv);
    chk(rv, 32'h0);
    chk({31'h00000000, irq}, 32'h0);
    $display("interrupt test done");
  endtask
  task automatic t_host(input logic [1:0] ha, input logic [31:0] es);
    wr(PPM_ADDR_MASK, 32'h00000003);
    wr(PPM_ADDR_MODE, mw(PPM_IRQ_BUF3, PPM_STEP_HOLD, 1'b0, PPM_MODE_ENH, 2'h0, 4'h0));
    @(posedge mclk);
    host_cs <= 1'b1;
    host_wr <= ha[0];
    host_rd <= ~ha[0];
    host_addr <= ha;
    @(posedge mclk);
    host_cs <= 1'b0;
    host_wr <= 1'b0;
    host_rd <= 1'b0;
    repeat (3) @(posedge mclk);
    rd(PPM_ADDR_STAT, rv);
    chk(rv, es);
    chk({31'h00000000, irq}, {31'h00000000, |es});
    wr(PPM_ADDR_STAT, 32'h00000003);
    $display("host access test done");
  endtask
  task automatic t_legacy();
    wr(PPM_ADDR_MASK, 32'h00000003);
    wr(PPM_ADDR_MODE, mw(PPM_IRQ_BUF3, PPM_STEP_BUF, 1'b0, PPM_MODE_LEGACY, 2'h0, 4'h0));
    for (int i = 0; i < 4; i++)
    begin
      rd(PPM_ADDR_STAT, rv);
      chk(rv, 32'h0);
      @(posedge mclk);
      host_cs <= 1'b1;
      host_wr <= 1'b1;
      @(posedge mclk);
      host_cs <= 1'b0;
      host_wr <= 1'b0;
    end
    repeat (2) @(posedge mclk);
    rd(PPM_ADDR_STAT, rv);
    chk(rv, 32'h00000002);
    wr(PPM_ADDR_STAT, 32'h00000003);
    $display("legacy slave test done");
  endtask
  // ==========================================================
  // clock, timeout and closing
  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
    begin
      $display("bench passed");
    end
    else
    begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      wrap_up();
    end
  end
  initial
  begin
    rst = 1'b1;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    host_cs = 1'b0;
    host_rd = 1'b0;
    host_wr = 1'b0;
    host_addr = 2'h0;
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    t_reset();
    t_timing(1'b0, PPM_MODE_M2, 1'b1, 2'h2, 4'h3, 3);
    t_timing(1'b0, PPM_MODE_M2, 1'b0, 2'h3, 4'h0, 1);
    t_timing(1'b0, PPM_MODE_M1, 1'b1, 2'h0, 4'hF, 1);
    t_timing(1'b1, PPM_MODE_M2, 1'b1, 2'h3, 4'h0, 1);
    t_timing(1'b1, PPM_MODE_M2, 1'b0, 2'h1, 4'h2, 2);
    t_dual();
    t_step(16'h7FFF, PPM_STEP_INC, 2'h0, 16'h8000);
    t_step(16'h7FFF, PPM_STEP_INC, 2'h3, 16'h4000);
    t_step(16'h4000, PPM_STEP_DEC, 2'h3, 16'h7FFF);
    t_step(16'h0000, PPM_STEP_DEC, 2'h0, 16'hFFFF);
    t_step(16'h1234, PPM_STEP_HOLD, 2'h0, 16'h1234);
    t_irq(PPM_IRQ_CYCLE, 32'h00000003, 32'h00000001);
    t_irq(PPM_IRQ_NONE, 32'h00000003, 32'h0);
    t_irq(PPM_IRQ_CYCLE, 32'h0, 32'h00000001);
    t_host(2'h1, 32'h0);
    t_host(2'h3, 32'h00000002);
    t_legacy();
    wrap_up();
  end
endmodule
`default_nettype wire
